// file: include/stats_pkg.sv
package stats_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned NUM_REGS = 128;
  localparam logic [15:0] STATS_FIRST = 16'h0801;
  localparam logic [15:0] STATS_LAST = 16'h0880;
  localparam logic [15:0] PORT_STRIDE = 16'h0020;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int unsigned ROUTE_REGS = 4;

  // network port group
  localparam logic [15:0] NET_RESET_RX = 16'h0801;
  localparam logic [15:0] NET_RING_EXH = 16'h0802;
  localparam logic [15:0] NET_BUF_TAKEN = 16'h0804;
  localparam logic [15:0] NET_FREE_EMPTY = 16'h0805;
  localparam logic [15:0] NET_TX_ACKED = 16'h0806;
  localparam logic [15:0] NET_ABANDONED = 16'h0807;
  localparam logic [15:0] NET_RETRANSMIT = 16'h0808;
  localparam logic [15:0] NET_BAD_ROUTE = 16'h0809;
  localparam logic [15:0] NET_ILL_QUERY = 16'h080a;
  localparam logic [15:0] NET_LOC_READ = 16'h080b;
  localparam logic [15:0] NET_LOC_WRITE = 16'h080c;
  localparam logic [15:0] NET_OPEN_CONN = 16'h080d;
  localparam logic [15:0] NET_OPEN_CLIENT = 16'h080e;
  localparam logic [15:0] NET_FOREIGN = 16'h080f;
  localparam logic [15:0] NET_FRAME_TX = 16'h0810;
  localparam logic [15:0] NET_FRAME_RX = 16'h0811;
  localparam logic [15:0] NET_COLLISION = 16'h0812;
  localparam logic [15:0] NET_EXCESS_COLL = 16'h0813;
  localparam logic [15:0] NET_CRC_ERR = 16'h0814;
  localparam logic [15:0] NET_FRAMING_ERR = 16'h0815;
  localparam logic [15:0] NET_SEQ_NAK = 16'h0816;
  localparam logic [15:0] NET_ROUTE = 16'h081c;
  localparam logic [15:0] NET_BUFFERS = 16'h0820;

  // data port 1 group; port n adds (n-1) * PORT_STRIDE
  localparam logic [15:0] P_PKT_RX = 16'h0821;
  localparam logic [15:0] P_NO_BUF = 16'h0822;
  localparam logic [15:0] P_INVALID = 16'h0823;
  localparam logic [15:0] P_TX_ACKED = 16'h0826;
  localparam logic [15:0] P_TX_FAILED = 16'h0827;
  localparam logic [15:0] P_TX_RETRY = 16'h0828;
  localparam logic [15:0] P_CHAR_ERR = 16'h082f;
  localparam logic [15:0] P_CHAR_TX = 16'h0830;
  localparam logic [15:0] P_CHAR_RX = 16'h0831;
  localparam logic [15:0] P_QUEUED = 16'h0837;
  localparam logic [15:0] P_BYTES_ACK = 16'h0838;
  localparam logic [15:0] P_ROUTE = 16'h083c;
  localparam logic [15:0] P_BUFFERS = 16'h0840;

  // backplane group
  localparam logic [15:0] BP_REPLY_RX = 16'h0861;
  localparam logic [15:0] BP_ERR_RESP = 16'h0862;
  localparam logic [15:0] BP_REPLY_DISC = 16'h0863;
  localparam logic [15:0] BP_MSG_GEN = 16'h0864;
  localparam logic [15:0] BP_NO_BUF = 16'h0865;
  localparam logic [15:0] BP_NO_CONTEXT = 16'h0867;
  localparam logic [15:0] BP_ACTIVE = 16'h0868;
  localparam logic [15:0] BP_LOGON_MSG = 16'h086b;
  localparam logic [15:0] BP_NOLOGON_MSG = 16'h086c;
  localparam logic [15:0] BP_OP_INIT = 16'h086e;
  localparam logic [15:0] BP_BAD_OPCODE = 16'h0870;
  localparam logic [15:0] BP_OP_FINISH = 16'h0871;
  localparam logic [15:0] BP_NO_RACK_ERR = 16'h0873;
  localparam logic [15:0] BP_RACK_SCAN = 16'h0874;
  localparam logic [15:0] BP_EOS_HOOK = 16'h0875;
  localparam logic [15:0] BP_USER_HOOK = 16'h0876;
  localparam logic [15:0] BP_QUEUE_DEPTH = 16'h0877;
  localparam logic [15:0] BP_LOGON_CLAIMED = 16'h0878;
  localparam logic [15:0] BP_POWERUP_HOOK = 16'h0879;
  localparam logic [15:0] BP_EXITDIM_HOOK = 16'h087a;
  localparam logic [15:0] BP_ROUTE = 16'h087c;
  localparam logic [15:0] BP_BUFFERS = 16'h0880;

  typedef struct packed {
    logic reset_rx;
    logic ring_exhausted;
    logic buf_taken;
    logic free_empty;
    logic tx_acked;
    logic conn_abandoned;
    logic retransmit;
    logic bad_route;
    logic illegal_query;
    logic local_read;
    logic local_write;
    logic foreign_pkt;
    logic frame_tx;
    logic frame_rx;
    logic collision;
    logic excess_coll;
    logic crc_err;
    logic framing_err;
    logic seq_nak;
  } net_ev_t;

  typedef struct packed {
    logic [15:0] open_conn;
    logic [15:0] open_client;
    logic [15:0] buffers;
  } net_gauge_t;

  typedef struct packed {
    logic pkt_rx;
    logic pkt_valid;
    logic no_buffer;
    logic invalid_pkt;
    logic tx_acked;
    logic tx_failed;
    logic tx_retry;
    logic char_err;
    logic char_tx;
    logic char_rx;
  } port_ev_t;

  typedef struct packed {
    logic [15:0] queued;
    logic [15:0] bytes_before_ack;
    logic [15:0] buffers;
  } port_gauge_t;

  typedef struct packed {
    logic reply_rx;
    logic err_resp;
    logic reply_discard;
    logic msg_gen;
    logic no_buffer;
    logic no_context;
    logic logon_msg;
    logic nologon_msg;
    logic op_init;
    logic bad_opcode;
    logic op_finish;
    logic no_rack_err;
    logic rack_scan;
    logic eos_hook;
    logic user_hook;
    logic powerup_hook;
    logic exitdim_hook;
  } bp_ev_t;

  typedef struct packed {
    logic [15:0] active_blocks;
    logic [15:0] queue_depth;
    logic [15:0] logon_claimed;
    logic [15:0] buffers;
  } bp_gauge_t;

  // route drops 1..8, drop 1 in the top byte
  typedef struct packed {
    logic        load;
    logic [63:0] drops;
  } route_t;

endpackage : stats_pkg

// file: verilog/port_statistics_counters.sv
`timescale 1ns/100ps
`default_nettype none

module port_statistics_counters
  import stats_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 2
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           reg_rdata,
  output logic                       reg_rd_valid,
  input  wire logic                  net_protocol_mode,
  input  wire net_ev_t               net_ev,
  input  wire net_gauge_t            net_gauge,
  input  wire route_t                net_route,
  input  wire logic [NUM_PORTS-1:0]  port_proprietary_mode,
  input  wire port_ev_t              port_ev    [NUM_PORTS],
  input  wire port_gauge_t           port_gauge [NUM_PORTS],
  input  wire route_t                port_route [NUM_PORTS],
  output logic      [NUM_PORTS-1:0]  port_nak,
  input  wire bp_ev_t                bp_ev,
  input  wire bp_gauge_t             bp_gauge,
  input  wire route_t                bp_route
);

  // only ports 1 and 2 have a place in the map
  if (NUM_PORTS < 1 || NUM_PORTS > 2) begin : g_bad_ports
    $error("NUM_PORTS must be 1 or 2");
  end

  function automatic logic [IDX_W-1:0] idx(input logic [15:0] off);
    logic [15:0] d;
    d = off - STATS_FIRST;
    return d[IDX_W-1:0];
  endfunction : idx

  function automatic logic [15:0] port_off(input logic [15:0] off, input int unsigned p);
    logic [15:0] step;
    step = PORT_STRIDE * p[15:0];
    return off + step;
  endfunction : port_off

  function automatic logic [15:0] route_word(input logic [63:0] drops, input int unsigned k);
    return drops[63-16*k -: 16];
  endfunction : route_word

  logic [DATA_W-1:0] cnt_reg   [NUM_REGS];
  logic [NUM_REGS-1:0] inc;
  logic [NUM_REGS-1:0] ld;
  logic [DATA_W-1:0] ld_val    [NUM_REGS];
  logic [NUM_REGS-1:0] storable;
  logic [NUM_REGS-1:0] gauge_sel;
  logic [DATA_W-1:0] gauge_val [NUM_REGS];
  logic              in_range;
  logic [IDX_W-1:0]  a_idx;
  logic [15:0]       a_diff;

  assign in_range = (reg_addr >= STATS_FIRST) && (reg_addr <= STATS_LAST);
  assign a_diff   = reg_addr - STATS_FIRST;
  assign a_idx    = a_diff[IDX_W-1:0];

  // increment requests from the event sources
  always_comb begin
    logic rx_ok;
    rx_ok = 1'b0;
    inc = '0;
    inc[idx(NET_RESET_RX)]    = net_ev.reset_rx;
    inc[idx(NET_RING_EXH)]    = net_ev.ring_exhausted;
    inc[idx(NET_BUF_TAKEN)]   = net_ev.buf_taken & net_protocol_mode;
    inc[idx(NET_FREE_EMPTY)]  = net_ev.free_empty & net_protocol_mode;
    inc[idx(NET_TX_ACKED)]    = net_ev.tx_acked;
    inc[idx(NET_ABANDONED)]   = net_ev.conn_abandoned;
    inc[idx(NET_RETRANSMIT)]  = net_ev.retransmit;
    inc[idx(NET_BAD_ROUTE)]   = net_ev.bad_route;
    inc[idx(NET_ILL_QUERY)]   = net_ev.illegal_query;
    inc[idx(NET_LOC_READ)]    = net_ev.local_read;
    inc[idx(NET_LOC_WRITE)]   = net_ev.local_write;
    inc[idx(NET_FOREIGN)]     = net_ev.foreign_pkt;
    inc[idx(NET_FRAME_TX)]    = net_ev.frame_tx;
    inc[idx(NET_FRAME_RX)]    = net_ev.frame_rx;
    inc[idx(NET_COLLISION)]   = net_ev.collision;
    inc[idx(NET_EXCESS_COLL)] = net_ev.excess_coll;
    inc[idx(NET_CRC_ERR)]     = net_ev.crc_err;
    inc[idx(NET_FRAMING_ERR)] = net_ev.framing_err;
    inc[idx(NET_SEQ_NAK)]     = net_ev.seq_nak;
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      // proprietary framing: only packets that passed checks count
      rx_ok = port_ev[p].pkt_rx & (~port_proprietary_mode[p] | port_ev[p].pkt_valid);
      inc[idx(port_off(P_PKT_RX, p))]    = rx_ok;
      inc[idx(port_off(P_NO_BUF, p))]    = port_ev[p].no_buffer;
      inc[idx(port_off(P_INVALID, p))]   = port_ev[p].invalid_pkt
                                           & port_proprietary_mode[p];
      inc[idx(port_off(P_TX_ACKED, p))]  = port_ev[p].tx_acked;
      inc[idx(port_off(P_TX_FAILED, p))] = port_ev[p].tx_failed;
      inc[idx(port_off(P_TX_RETRY, p))]  = port_ev[p].tx_retry;
      inc[idx(port_off(P_CHAR_ERR, p))]  = port_ev[p].char_err;
      inc[idx(port_off(P_CHAR_TX, p))]   = port_ev[p].char_tx;
      inc[idx(port_off(P_CHAR_RX, p))]   = port_ev[p].char_rx;
    end
    inc[idx(BP_REPLY_RX)]     = bp_ev.reply_rx;
    // a no-rack error response is also an error response
    inc[idx(BP_ERR_RESP)]     = bp_ev.err_resp | bp_ev.no_rack_err;
    inc[idx(BP_NO_RACK_ERR)]  = bp_ev.no_rack_err;
    inc[idx(BP_REPLY_DISC)]   = bp_ev.reply_discard;
    inc[idx(BP_MSG_GEN)]      = bp_ev.msg_gen;
    inc[idx(BP_NO_BUF)]       = bp_ev.no_buffer;
    inc[idx(BP_NO_CONTEXT)]   = bp_ev.no_context;
    inc[idx(BP_BAD_OPCODE)]   = bp_ev.bad_opcode;
    inc[idx(BP_LOGON_MSG)]    = bp_ev.logon_msg;
    inc[idx(BP_NOLOGON_MSG)]  = bp_ev.nologon_msg;
    inc[idx(BP_OP_INIT)]      = bp_ev.op_init;
    inc[idx(BP_OP_FINISH)]    = bp_ev.op_finish;
    inc[idx(BP_RACK_SCAN)]    = bp_ev.rack_scan;
    inc[idx(BP_EOS_HOOK)]     = bp_ev.eos_hook;
    inc[idx(BP_USER_HOOK)]    = bp_ev.user_hook;
    inc[idx(BP_POWERUP_HOOK)] = bp_ev.powerup_hook;
    inc[idx(BP_EXITDIM_HOOK)] = bp_ev.exitdim_hook;
  end

  // route captures, one group of four words per port and one for the backplane
  always_comb begin
    ld = '0;
    for (int unsigned i = 0; i < NUM_REGS; i++) begin
      ld_val[i] = CNT_RESET;
    end
    for (int unsigned k = 0; k < ROUTE_REGS; k++) begin
      ld[idx(NET_ROUTE) + k[IDX_W-1:0]]     = net_route.load;
      ld_val[idx(NET_ROUTE) + k[IDX_W-1:0]] = route_word(net_route.drops, k);
      ld[idx(BP_ROUTE) + k[IDX_W-1:0]]      = bp_route.load;
      ld_val[idx(BP_ROUTE) + k[IDX_W-1:0]]  = route_word(bp_route.drops, k);
      for (int unsigned p = 0; p < NUM_PORTS; p++) begin
        ld[idx(port_off(P_ROUTE, p)) + k[IDX_W-1:0]]     = port_route[p].load;
        ld_val[idx(port_off(P_ROUTE, p)) + k[IDX_W-1:0]] =
          route_word(port_route[p].drops, k);
      end
    end
  end

  // live gauges: read straight from the sources, never stored
  always_comb begin
    gauge_sel = '0;
    for (int unsigned i = 0; i < NUM_REGS; i++) begin
      gauge_val[i] = CNT_RESET;
    end
    gauge_sel[idx(NET_OPEN_CONN)]    = 1'b1;
    gauge_val[idx(NET_OPEN_CONN)]    = net_gauge.open_conn;
    gauge_sel[idx(NET_OPEN_CLIENT)]  = 1'b1;
    gauge_val[idx(NET_OPEN_CLIENT)]  = net_gauge.open_client;
    gauge_sel[idx(NET_BUFFERS)]      = 1'b1;
    gauge_val[idx(NET_BUFFERS)]      = net_gauge.buffers;
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      gauge_sel[idx(port_off(P_QUEUED, p))]    = 1'b1;
      gauge_val[idx(port_off(P_QUEUED, p))]    = port_gauge[p].queued;
      gauge_sel[idx(port_off(P_BYTES_ACK, p))] = 1'b1;
      gauge_val[idx(port_off(P_BYTES_ACK, p))] = port_gauge[p].bytes_before_ack;
      gauge_sel[idx(port_off(P_BUFFERS, p))]   = 1'b1;
      gauge_val[idx(port_off(P_BUFFERS, p))]   = port_gauge[p].buffers;
    end
    gauge_sel[idx(BP_ACTIVE)]        = 1'b1;
    gauge_val[idx(BP_ACTIVE)]        = bp_gauge.active_blocks;
    gauge_sel[idx(BP_QUEUE_DEPTH)]   = 1'b1;
    gauge_val[idx(BP_QUEUE_DEPTH)]   = bp_gauge.queue_depth;
    gauge_sel[idx(BP_LOGON_CLAIMED)] = 1'b1;
    gauge_val[idx(BP_LOGON_CLAIMED)] = bp_gauge.logon_claimed;
    gauge_sel[idx(BP_BUFFERS)]       = 1'b1;
    gauge_val[idx(BP_BUFFERS)]       = bp_gauge.buffers;
  end

  // everything that counts or captures can be written; the rest is reserved
  assign storable = inc | ld | {NUM_REGS{1'b0}} | cnt_present();

  function automatic logic [NUM_REGS-1:0] cnt_present();
    logic [NUM_REGS-1:0] m;
    m = '0;
    m[idx(NET_RESET_RX)]    = 1'b1;
    m[idx(NET_RING_EXH)]    = 1'b1;
    m[idx(NET_BUF_TAKEN)]   = 1'b1;
    m[idx(NET_FREE_EMPTY)]  = 1'b1;
    for (logic [15:0] o = NET_TX_ACKED; o <= NET_LOC_WRITE; o++) begin
      m[idx(o)] = 1'b1;
    end
    for (logic [15:0] o = NET_FOREIGN; o <= NET_SEQ_NAK; o++) begin
      m[idx(o)] = 1'b1;
    end
    for (int unsigned k = 0; k < ROUTE_REGS; k++) begin
      m[idx(NET_ROUTE) + k[IDX_W-1:0]] = 1'b1;
      m[idx(BP_ROUTE) + k[IDX_W-1:0]]  = 1'b1;
    end
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      for (int unsigned k = 0; k < 3; k++) begin
        m[idx(port_off(P_PKT_RX, p)) + k[IDX_W-1:0]]    = 1'b1;
        m[idx(port_off(P_TX_ACKED, p)) + k[IDX_W-1:0]]  = 1'b1;
        m[idx(port_off(P_CHAR_ERR, p)) + k[IDX_W-1:0]]  = 1'b1;
      end
      for (int unsigned k = 0; k < ROUTE_REGS; k++) begin
        m[idx(port_off(P_ROUTE, p)) + k[IDX_W-1:0]] = 1'b1;
      end
    end
    for (logic [15:0] o = BP_REPLY_RX; o <= BP_NO_BUF; o++) begin
      m[idx(o)] = 1'b1;
    end
    m[idx(BP_NO_CONTEXT)]   = 1'b1;
    m[idx(BP_LOGON_MSG)]    = 1'b1;
    m[idx(BP_NOLOGON_MSG)]  = 1'b1;
    m[idx(BP_OP_INIT)]      = 1'b1;
    m[idx(BP_BAD_OPCODE)]   = 1'b1;
    m[idx(BP_OP_FINISH)]    = 1'b1;
    for (logic [15:0] o = BP_NO_RACK_ERR; o <= BP_USER_HOOK; o++) begin
      m[idx(o)] = 1'b1;
    end
    m[idx(BP_POWERUP_HOOK)] = 1'b1;
    m[idx(BP_EXITDIM_HOOK)] = 1'b1;
    return m;
  endfunction : cnt_present

  // counter storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int unsigned i = 0; i < NUM_REGS; i++) begin
        cnt_reg[i] <= CNT_RESET;
      end
    end else begin
      for (int unsigned i = 0; i < NUM_REGS; i++) begin
        // host write wins over a same-cycle event
        if (reg_wr && in_range && a_idx == i[IDX_W-1:0] && storable[i]) begin
          cnt_reg[i] <= reg_wdata;
        end else if (ld[i]) begin
          cnt_reg[i] <= ld_val[i];
        end else if (inc[i]) begin
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata    <= CNT_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        if (!in_range) begin
          reg_rdata <= CNT_RESET;
        end else if (gauge_sel[a_idx]) begin
          reg_rdata <= gauge_val[a_idx];
        end else if (storable[a_idx]) begin
          reg_rdata <= cnt_reg[a_idx];
        end else begin
          reg_rdata <= CNT_RESET;
        end
      end
    end
  end

  // nak towards the serial engine, one cycle after an invalid packet on a port whose mode bit is set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_nak <= '0;
    end else begin
      for (int unsigned p = 0; p < NUM_PORTS; p++) begin
        port_nak[p] <= port_ev[p].invalid_pkt & port_proprietary_mode[p];
      end
    end
  end

endmodule : port_statistics_counters

`default_nettype wire

// file: verif/stats_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module stats_monitor
  import stats_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [15:0]          reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic [15:0]          reg_rdata,
  input wire logic                 reg_rd_valid,
  input wire net_gauge_t           net_gauge,
  input wire net_ev_t              net_ev,
  input wire logic [NUM_PORTS-1:0] port_proprietary_mode,
  input wire port_ev_t             port_ev [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] port_nak
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (reg_rd |=> reg_rd_valid)
    else $error("read strobe got no valid");
  a_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd))
    else $error("valid without read strobe");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < STATS_FIRST ||
    reg_addr > STATS_LAST) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_reserved_zero: assert property (reg_rd && reg_addr == 16'h0803
    |=> reg_rdata == 16'h0000) else $error("reserved read not zero");
  a_zero_clears: assert property (reg_wr && reg_wdata == 16'h0000 &&
    reg_addr == NET_FRAME_TX ##1 !reg_wr && !net_ev.frame_tx ##1 reg_rd &&
    reg_addr == NET_FRAME_TX |=> reg_rdata == 16'h0000) else $error("zero write did not clear");
  a_gauge_live: assert property (reg_rd && reg_addr == NET_OPEN_CONN
    |=> reg_rdata == $past(net_gauge.open_conn)) else $error("gauge read not live");
  a_nak_raise: assert property (port_ev[0].invalid_pkt && port_proprietary_mode[0]
    |=> port_nak[0]) else $error("invalid packet not refused");
  a_nak_cause: assert property (port_nak[0]
    |-> $past(port_ev[0].invalid_pkt && port_proprietary_mode[0])) else $error("stray nak");
  a_nak_quiet: assert property (port_ev[1].invalid_pkt && !port_proprietary_mode[1]
    |=> !port_nak[1]) else $error("nak outside proprietary mode");
  c_read: cover property (reg_rd_valid);
  c_nak: cover property (port_nak[0]);
  c_clear: cover property (reg_wr && reg_wdata == 16'h0000);
  c_clear_race: cover property (reg_wr && reg_addr == NET_FRAME_TX && net_ev.frame_tx);
endmodule : stats_monitor
bind port_statistics_counters stats_monitor #(.NUM_PORTS(NUM_PORTS)) mon (.clk(clk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .net_gauge(net_gauge), .net_ev(net_ev), .port_proprietary_mode(port_proprietary_mode),
  .port_ev(port_ev), .port_nak(port_nak));
`default_nettype wire

// file: verif/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic   clk,
  output var  logic   reg_wr,
  output var  logic   reg_rd,
  output var  logic [15:0] reg_addr,
  output var  logic [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // local access only, never forwarded to another port
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : acc
  // released bus shows inverted values so stale data cannot pass
  task automatic rel();
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask : rel
endmodule : host_model
`default_nettype wire

// file: verif/port_statistics_counters_test.sv
`timescale 1ns/100ps
`default_nettype none
module port_statistics_counters_test;
  import stats_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rd_valid, net_mode;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, exp_q [$];
  logic [1:0] prop_mode, port_nak;
  logic [31:0] seed;
  int error_cnt, compares, cyc;
  logic [15:0] nak_exp = 16'h0000, nak_seen = 16'h0000;
  net_ev_t nev;
  net_gauge_t ng;
  route_t nr, br;
  bp_ev_t bev;
  bp_gauge_t bg;
  port_ev_t pev [2];
  port_gauge_t pg [2];
  route_t pr [2];
  logic [15:0] na [19] = '{16'h0801, 16'h0802, 16'h0804, 16'h0805, 16'h0806, 16'h0807,
    16'h0808, 16'h0809, 16'h080a, 16'h080b, 16'h080c, 16'h080f, 16'h0810, 16'h0811,
    16'h0812, 16'h0813, 16'h0814, 16'h0815, 16'h0816};
  logic [15:0] pa [10] = '{16'h0821, 16'h0000, 16'h0822, 16'h0823, 16'h0826, 16'h0827,
    16'h0828, 16'h082f, 16'h0830, 16'h0831};
  logic [15:0] ba [17] = '{16'h0861, 16'h0862, 16'h0863, 16'h0864, 16'h0865, 16'h0867,
    16'h086b, 16'h086c, 16'h086e, 16'h0870, 16'h0871, 16'h0873, 16'h0874, 16'h0875,
    16'h0876, 16'h0879, 16'h087a};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  port_statistics_counters #(.NUM_PORTS(2)) DUT (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .net_protocol_mode(net_mode),
    .net_ev(nev), .net_gauge(ng), .net_route(nr), .port_proprietary_mode(prop_mode),
    .port_ev(pev), .port_gauge(pg), .port_route(pr), .port_nak(port_nak), .bp_ev(bev),
    .bp_gauge(bg), .bp_route(br));
  host_model hm (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_nak(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t nak count %h want %h", $time, got, exp);
    end
  endtask : chk_nak
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    hm.acc(1'b0, a, 16'h0000);
    hm.rel();
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    hm.acc(1'b1, a, d);
    hm.rel();
  endtask : wr
  // g: 0 net, 1 port 0 with valid qualifier, 2 backplane, 3 port 1 raw
  task automatic pulse(input int g, input int b, input int n);
    if (g == 1 && b == 6) begin
      nak_exp = nak_exp + 16'(n);
    end
    @(posedge clk);
    case (g)
      0: nev[b] <= 1'b1;
      1: pev[0] <= port_ev_t'((10'h001 << b) | ((b == 9) ? 10'h100 : 10'h000));
      2: bev[b] <= 1'b1;
      default: pev[1] <= port_ev_t'(10'h001 << b);
    endcase
    repeat (n) @(posedge clk);
    nev <= '0;
    bev <= '0;
    pev[0] <= '0;
    pev[1] <= '0;
  endtask : pulse
  task automatic group(input int g, input logic [15:0] a, input int b);
    if (a != 16'h0000) begin
      wr(a, 16'h0000);
      pulse(g, b, 3);
      rd(a, 16'h0003);
    end
  endtask : group
  always @(posedge clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("BAD %0t unexpected read", $time);
      end else
        chk(reg_rdata, exp_q.pop_front());
    end
  end
  // every nak cycle counts once; an unknown poisons the total
  always @(posedge clk) begin
    nak_seen <= nak_seen + 16'(port_nak[0]) + 16'(port_nak[1]);
  end
  // ceiling well above the roughly 460 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      wrap_up();
    end
  end
  initial begin
    {sys_rst, net_mode, prop_mode, nev, bev, ng, bg, nr, br} = '1;
    {nev, bev, nr, br, ng, bg} = '0;
    prop_mode = 2'b01;
    pev = '{'0, '0};
    pg = '{'0, '0};
    pr = '{'0, '0};
    seed = 32'h0000_3db5;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(NET_FRAME_TX, 16'h0000);
    rd(BP_OP_FINISH, 16'h0000);
    for (int j = 0; j < 19; j++) group(0, na[j], 18 - j);
    for (int j = 0; j < 10; j++) group(1, pa[j], 9 - j);
    for (int j = 0; j < 17; j++) group(2, ba[j], 16 - j);
    $display("event test done");
    net_mode <= 1'b0;
    pulse(0, 16, 2);
    rd(NET_BUF_TAKEN, 16'h0003);
    pulse(3, 9, 2);
    pulse(3, 6, 1);
    prop_mode <= 2'b11;
    pulse(3, 9, 2);
    rd(P_PKT_RX + PORT_STRIDE, 16'h0002);
    rd(P_INVALID + PORT_STRIDE, 16'h0000);
    rd(P_PKT_RX, 16'h0003);
    $display("mode test done");
    @(posedge clk);
    seed = lfsr(seed);
    ng <= {seed, seed[23:8]};
    seed = lfsr(seed);
    pg[0] <= {seed, seed[15:0]};
    bg <= {seed, ~seed};
    seed = lfsr(seed);
    nr <= {1'b1, seed, ~seed};
    pr[1] <= {1'b1, ~seed, seed};
    br <= {1'b1, seed[15:0], ~seed, seed[31:16]};
    @(posedge clk);
    nr.load <= 1'b0;
    pr[1].load <= 1'b0;
    br.load <= 1'b0;
    wr(NET_OPEN_CONN, 16'h1234);
    rd(NET_OPEN_CONN, ng.open_conn);
    rd(NET_OPEN_CLIENT, ng.open_client);
    rd(NET_BUFFERS, ng.buffers);
    rd(P_QUEUED, pg[0].queued);
    rd(P_BYTES_ACK, pg[0].bytes_before_ack);
    rd(P_BUFFERS, pg[0].buffers);
    rd(BP_ACTIVE, bg.active_blocks);
    rd(BP_LOGON_CLAIMED, bg.logon_claimed);
    rd(BP_BUFFERS, bg.buffers);
    rd(BP_QUEUE_DEPTH, bg.queue_depth);
    for (int k = 0; k < 4; k++) begin
      rd(NET_ROUTE + 16'(k), nr.drops[63 - 16 * k -: 16]);
      rd(P_ROUTE + PORT_STRIDE + 16'(k), pr[1].drops[63 - 16 * k -: 16]);
      rd(BP_ROUTE + 16'(k), br.drops[63 - 16 * k -: 16]);
    end
    $display("gauge test done");
    wr(P_CHAR_TX, 16'hffff);
    pulse(1, 1, 1);
    rd(P_CHAR_TX, 16'h0000);
    wr(16'h0803, 16'h5a5a);
    rd(16'h0803, 16'h0000);
    rd(16'h0900, 16'h0000);
    fork
      begin
        hm.acc(1'b1, NET_FRAME_TX, 16'h0000);
        hm.rel();
      end
      pulse(0, 6, 1);
    join
    rd(NET_FRAME_TX, 16'h0000);
    $display("edge test done");
    // let the last read answer land before reset wipes it
    repeat (2) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(P_PKT_RX, 16'h0000);
    rd(NET_ROUTE, 16'h0000);
    $display("reset test done");
    chk_nak(nak_seen, nak_exp);
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("BAD %0t reads missing", $time);
    end
    wrap_up();
  end
endmodule : port_statistics_counters_test
`default_nettype wire
